//--- logic/relay_wdog_defs.svh
// Purpose: shared constants of the relay board heater watchdog
// Assumes: 250 MHz board clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef RELAY_WDOG_DEFS_SVH
`define RELAY_WDOG_DEFS_SVH

`define CLK_FREQ_HZ 64'd250000000
`define HB_PERIOD_S 64'd3
`define WDOG_TIMEOUT_S 64'd30
`define WDOG_CYCLES (`WDOG_TIMEOUT_S * `CLK_FREQ_HZ)
`define WDOG_CNT_W 33
`define BUS_ADDR 7'h20
`define CMD_RESET 8'h00
`define SYNC_IDLE 3'h3
`define BIT_CNT_W 4
`define BITS_PER_BYTE 4'h8

`endif

//--- logic/relay_wdog_pkg.sv
// Purpose: types of the relay board heater watchdog
// Assumes: nothing
// Notes: command byte layout is the struct bit order
package relay_wdog_pkg;

	typedef struct packed {
		logic [4:0] relay;
		logic opt_heater;
		logic main_heater;
		logic heartbeat;
	} cmd_t;

	typedef struct packed {
		logic fitted;
		logic sda;
		logic scl;
	} pins_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK_A = 6'h04,
		ST_DATA = 6'h08,
		ST_ACK_D = 6'h10,
		ST_SKIP = 6'h20
	} bus_state_t;

endpackage : relay_wdog_pkg

//--- logic/relay_board_heater_watchdog.sv
// Purpose: relay board bus receiver, heater watchdog and status indicators
// Assumes: host is the bus master and writes one command byte per frame
// Notes: write-only slave; reads are not acknowledged
// Operation
// - heartbeat held in one state 30 seconds forces all heaters off
// - each indicator follows its function; heater indicator lit while heating
// - optional heater and its indicator active only when optional sensor fitted
// - heartbeat indicator driven only from host-written state, no local toggling
// - bus command words decoded onto relay and switch outputs
`timescale 1ns/1ns
`include "relay_wdog_defs.svh"

module relay_board_heater_watchdog #(
	parameter logic [`WDOG_CNT_W-1:0] WDOG_CYCLES = `WDOG_CNT_W'(`WDOG_CYCLES)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// board strap
	input wire logic opt_sensor_fitted_i,
	// switched outputs
	output logic main_heater_o,
	output logic opt_heater_o,
	output logic [4:0] relay_o,
	// indicators
	output logic heartbeat_indicator_o,
	output logic main_sensor_heater_indicator_o,
	output logic optional_cell_heater_indicator_o,
	output logic wdog_trip_o
);

	relay_wdog_pkg::pins_t s1_q, s2_q, s3_q, filt_q, filt_prev_q;
	relay_wdog_pkg::bus_state_t state_q;
	relay_wdog_pkg::cmd_t cmd_q;
	logic [`BIT_CNT_W-1:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic cmd_load;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic hb_seen_q, hb_change;
	logic [`WDOG_CNT_W-1:0] wdog_cnt_q;
	logic trip_q;

	// three-stage pin synchroniser, change accepted when stages two and three agree
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= `SYNC_IDLE;
			s2_q <= `SYNC_IDLE;
			s3_q <= `SYNC_IDLE;
			filt_q <= `SYNC_IDLE;
			filt_prev_q <= `SYNC_IDLE;
		end else begin
			s1_q <= {opt_sensor_fitted_i, sda_i, scl_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (s2_q == s3_q) ? s3_q : filt_q;
			filt_prev_q <= filt_q;
		end
	end

	assign scl_rise = filt_q.scl && !filt_prev_q.scl;
	assign scl_fall = !filt_q.scl && filt_prev_q.scl;
	assign start_seen = filt_q.scl && filt_prev_q.scl && filt_prev_q.sda && !filt_q.sda;
	assign stop_seen = filt_q.scl && filt_prev_q.scl && !filt_prev_q.sda && filt_q.sda;
	assign cmd_load = (state_q == relay_wdog_pkg::ST_DATA) && scl_fall && (bit_cnt_q == `BITS_PER_BYTE);

	// bus frame state
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= relay_wdog_pkg::ST_IDLE;
			bit_cnt_q <= '0;
		end else if (start_seen) begin
			state_q <= relay_wdog_pkg::ST_ADDR;
			bit_cnt_q <= '0;
		end else if (stop_seen) begin
			state_q <= relay_wdog_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				relay_wdog_pkg::ST_IDLE, relay_wdog_pkg::ST_SKIP: begin
				end
				relay_wdog_pkg::ST_ADDR: begin
					if (scl_rise && bit_cnt_q < `BITS_PER_BYTE)
						bit_cnt_q <= bit_cnt_q + `BIT_CNT_W'(1);
					if (scl_fall && bit_cnt_q == `BITS_PER_BYTE)
						state_q <= (shift_q == {`BUS_ADDR, 1'b0}) ? relay_wdog_pkg::ST_ACK_A
							: relay_wdog_pkg::ST_SKIP;
				end
				relay_wdog_pkg::ST_ACK_A, relay_wdog_pkg::ST_ACK_D: begin
					if (scl_fall) begin
						state_q <= relay_wdog_pkg::ST_DATA;
						bit_cnt_q <= '0;
					end
				end
				relay_wdog_pkg::ST_DATA: begin
					if (scl_rise && bit_cnt_q < `BITS_PER_BYTE)
						bit_cnt_q <= bit_cnt_q + `BIT_CNT_W'(1);
					if (cmd_load)
						state_q <= relay_wdog_pkg::ST_ACK_D;
				end
			endcase
		end
	end

	// serial shift, msb first
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			shift_q <= '0;
		else if (scl_rise && bit_cnt_q < `BITS_PER_BYTE)
			shift_q <= {shift_q[6:0], filt_q.sda};
	end

	// acknowledge drive, open drain low
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			sda_oe_o <= (state_q == relay_wdog_pkg::ST_ACK_A) || (state_q == relay_wdog_pkg::ST_ACK_D);
		end
	end

	// command word capture
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cmd_q <= `CMD_RESET;
		else if (cmd_load)
			cmd_q <= shift_q;
	end

	// heartbeat watchdog
	// a heartbeat change in the expiry cycle wins: no trip
	assign hb_change = cmd_q.heartbeat != hb_seen_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hb_seen_q <= 1'b0;
			wdog_cnt_q <= '0;
			trip_q <= 1'b0;
		end else begin
			hb_seen_q <= cmd_q.heartbeat;
			if (hb_change) begin
				wdog_cnt_q <= '0;
				trip_q <= 1'b0;
			end else if (wdog_cnt_q >= WDOG_CYCLES - `WDOG_CNT_W'(1)) begin
				trip_q <= 1'b1;
			end else begin
				wdog_cnt_q <= wdog_cnt_q + `WDOG_CNT_W'(1);
			end
		end
	end

	// outputs and indicators
	// trip gates heaters and their indicators alike
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			main_heater_o <= 1'b0;
			opt_heater_o <= 1'b0;
			relay_o <= '0;
			heartbeat_indicator_o <= 1'b0;
			main_sensor_heater_indicator_o <= 1'b0;
			optional_cell_heater_indicator_o <= 1'b0;
			wdog_trip_o <= 1'b0;
		end else begin
			main_heater_o <= cmd_q.main_heater && !trip_q;
			opt_heater_o <= cmd_q.opt_heater && !trip_q && filt_q.fitted;
			relay_o <= cmd_q.relay;
			heartbeat_indicator_o <= cmd_q.heartbeat;
			main_sensor_heater_indicator_o <= cmd_q.main_heater && !trip_q;
			optional_cell_heater_indicator_o <= cmd_q.opt_heater && !trip_q && filt_q.fitted;
			wdog_trip_o <= trip_q;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	trip_forces_off_a: assert property (trip_q |=> !main_heater_o && !opt_heater_o)
		else $error("heater on while watchdog tripped");
	timeout_trips_a: assert property ((wdog_cnt_q == WDOG_CYCLES - `WDOG_CNT_W'(1)) && !hb_change |=> trip_q)
		else $error("watchdog did not trip at timeout");
	indicator_follows_a: assert property (main_sensor_heater_indicator_o == main_heater_o
		&& optional_cell_heater_indicator_o == opt_heater_o)
		else $error("heater indicator differs from heater");
	opt_absent_off_a: assert property (!filt_q.fitted |=> !opt_heater_o && !optional_cell_heater_indicator_o)
		else $error("optional heater active without sensor");
	hb_from_host_a: assert property ($changed(heartbeat_indicator_o) |-> $past(cmd_load, 2))
		else $error("heartbeat indicator changed without bus write");
	cmd_applied_a: assert property (cmd_load |-> ##2 relay_o == $past(shift_q[7:3], 2))
		else $error("relay outputs do not match command");
	trip_holds_a: assert property (trip_q && !hb_change |=> trip_q)
		else $error("watchdog released without heartbeat toggle");
	trip_release_a: assert property (trip_q && hb_change |=> !trip_q ##1 (main_heater_o == $past(cmd_q.main_heater)))
		else $error("heaters not restored after heartbeat");

	// counter, output stage and refused frames
	cnt_restart_a: assert property (hb_change |=> wdog_cnt_q == '0)
		else $error("watchdog timer not restarted by heartbeat");
	trip_output_a: assert property (wdog_trip_o == $past(trip_q))
		else $error("trip output does not follow watchdog state");
	hb_indicator_a: assert property (heartbeat_indicator_o == $past(cmd_q.heartbeat))
		else $error("heartbeat indicator differs from host state");
	main_follows_a: assert property (!trip_q |=> main_heater_o == $past(cmd_q.main_heater))
		else $error("main heater differs from command");
	opt_follows_a: assert property (filt_q.fitted && !trip_q |=> opt_heater_o == $past(cmd_q.opt_heater))
		else $error("optional heater differs from command");
	skip_no_ack_a: assert property (state_q == relay_wdog_pkg::ST_SKIP |-> !cmd_load && !sda_oe_o)
		else $error("refused frame acknowledged or loaded");

	cmd_write_c: cover property (cmd_load);
	trip_seen_c: cover property ($rose(trip_q));
	trip_recover_c: cover property (trip_q ##1 !trip_q);
	skip_frame_c: cover property (state_q == relay_wdog_pkg::ST_SKIP);
	opt_blocked_c: cover property (cmd_q.opt_heater && !filt_q.fitted);

endmodule : relay_board_heater_watchdog

//--- bench/i2c_host_model.sv
// Purpose: bus master model standing in for the host processor
// Assumes: open-drain lines with pull-ups, 40 ns bus phases
// Notes: one address byte, one command byte per frame
`timescale 1ns/1ns
module i2c_host_model (
	// bus lines
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i,
	// ack seen on the last byte
	output logic ack_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		ack_o = 1'b0;
	end
	task automatic send(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			#20 sda_o = (i == 0) ? 1'b1 : b[i-1];
			#20 scl_o = 1'b1;
			#40 ack_o = ~sda_i;
			scl_o = 1'b0;
		end
	endtask : send
	// host sends each heartbeat state by a bus write
	task automatic write_cmd(input logic [7:0] addr, input logic [7:0] cmd);
		sda_o = 1'b0;
		#40 scl_o = 1'b0;
		send(addr);
		send(cmd);
		#20 sda_o = 1'b0;
		#20 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#40;
	endtask : write_cmd
endmodule : i2c_host_model

//--- bench/relay_board_heater_watchdog_test.sv
// Purpose: self-checking bench of the heater watchdog
// Assumes: shortened watchdog count
// Notes: host model drives the bus
`timescale 1ns/1ns
module relay_board_heater_watchdog_test;
	localparam logic [32:0] WDOG = 33'h7D0;
	// board address with the write bit
	localparam logic [7:0] ADDR_W = 8'h40;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic fit = 1'b1;
	logic scl, sda_h, sda_d, sda_oe, ack, mh, oh, hb, mi, oi, trip;
	logic [4:0] relay;
	wire sda_w = sda_h & ~(sda_oe & ~sda_d);
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	i2c_host_model i2c_host_model_inst (.scl_o(scl), .sda_o(sda_h), .sda_i(sda_w), .ack_o(ack));
	relay_board_heater_watchdog #(.WDOG_CYCLES(WDOG)) relay_board_heater_watchdog_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
		.sda_oe_o(sda_oe), .opt_sensor_fitted_i(fit), .main_heater_o(mh), .opt_heater_o(oh),
		.relay_o(relay), .heartbeat_indicator_o(hb), .main_sensor_heater_indicator_o(mi),
		.optional_cell_heater_indicator_o(oi), .wdog_trip_o(trip));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c);
		i2c_host_model_inst.write_cmd(ADDR_W, c);
		tick(20);
	endtask : wr
	task automatic t_commands();
		logic [7:0] tbl [3] = '{8'hAF, 8'h52, 8'h0D};
		foreach (tbl[i]) begin
			wr(tbl[i]);
			chk({relay, oh, mh, hb}, tbl[i]);
			chk({6'h00, oi, mi}, {6'h00, tbl[i][2:1]});
			chk({7'h00, ack}, 8'h01);
		end
	endtask : t_commands
	task automatic t_optional();
		fit = 1'b0;
		wr(8'h06);
		chk({4'h0, oh, oi, mh, mi}, 8'h03);
		fit = 1'b1;
		tick(10);
		chk({4'h0, oh, oi, mh, mi}, 8'h0F);
	endtask : t_optional
	task automatic t_watchdog();
		wr(8'h07);
		tick(int'(WDOG) - 100);
		chk({trip, mh, oh, mi, oi}, 8'h0F);
		tick(200);
		chk({trip, mh, oh, mi, oi, hb}, 8'h21);
		wr(8'h07);
		chk({trip, mh, oh, mi, oi}, 8'h10);
		wr(8'h06);
		chk({trip, mh, oh, mi, oi}, 8'h0F);
	endtask : t_watchdog
	task automatic t_bad_addr();
		i2c_host_model_inst.write_cmd(8'h41, 8'hF9);
		tick(20);
		chk({7'h00, ack}, 8'h00);
		chk({relay, oh, mh, hb}, 8'h06);
		i2c_host_model_inst.write_cmd(8'h42, 8'hF9);
		tick(20);
		chk({7'h00, ack}, 8'h00);
		chk({relay, oh, mh, hb}, 8'h06);
	endtask : t_bad_addr
	task automatic t_reset();
		reset_n_i = 1'b0;
		tick(2);
		chk({relay, oh, mh, hb}, 8'h00);
		chk({5'h00, oi, mi, trip}, 8'h00);
		reset_n_i = 1'b1;
		tick(8);
		wr(8'h03);
		chk({relay, oh, mh, hb}, 8'h03);
		chk({6'h00, oi, mi}, 8'h01);
	endtask : t_reset
	task automatic summarize();
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		tick(4);
		reset_n_i = 1'b1;
		tick(8);
		t_commands();
		t_optional();
		t_watchdog();
		t_bad_addr();
		t_reset();
		summarize();
	end
endmodule : relay_board_heater_watchdog_test
